/* hdl/qsadc_pkg.sv */
// Shared constants and types for the four-channel SAR converter control
package qsadc_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int RESULT_W = 12;
	localparam int CHAN_NUM = 4;
	localparam int ADDR_W   = 2;
	localparam int PHASE_W  = 4;
	localparam int CTRL_SH_W = 7;

	// ****************************************************************
	// Conversion slots, counted as falling edges seen so far (mod 16)
	// ****************************************************************
	localparam logic [PHASE_W-1:0] PH_FRAME_START = 4'h0;
	localparam logic [PHASE_W-1:0] PH_TRACK_LAST  = 4'h3;
	localparam logic [PHASE_W-1:0] PH_HOLD        = 4'h4;
	localparam logic [PHASE_W-1:0] PH_MSB         = 4'h5;
	localparam logic [PHASE_W-1:0] PH_LAST        = 4'hf;
	localparam logic [PHASE_W-1:0] PH_STEP        = 4'h1;

	// Rising edges seen so far: control word occupies the first eight
	localparam logic [PHASE_W-1:0] RISE_CTRL_LAST = 4'h7;
	localparam logic [PHASE_W-1:0] RISE_CTRL_END  = 4'h8;

	// Address field of the control word, as seen in the shift register
	// one edge before the word completes (word bits 4:3)
	localparam int ADDR_SH_HI = 3;
	localparam int ADDR_SH_LO = 2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [ADDR_W-1:0]    CHAN_RESET = 2'h0;
	localparam logic [RESULT_W-1:0]  CODE_ZERO  = 12'h000;
	localparam logic [RESULT_W-1:0]  CODE_ONE   = 12'h001;
	localparam int                   MSB_IDX    = RESULT_W - 1;

	// ****************************************************************
	// Converter mode
	// ****************************************************************
	typedef enum logic [1:0] {
		QSADC_IDLE  = 2'b00,
		QSADC_TRACK = 2'b01,
		QSADC_HOLD  = 2'b10
	} qsadc_mode_e;

endpackage

/* hdl/qsadc_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module qsadc_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // qsadc_sync2

/* hdl/qsadc_sar.sv */
// Successive-approximation register stepping one decision per falling edge
`timescale 1ns/1ps
module qsadc_sar import qsadc_pkg::*; (
	// Internal serial clock, decisions on its falling edge
	input  wire logic                sclk_int,
	input  wire logic                frame_rst_n,
	// Control
	input  wire logic                load,
	input  wire logic                step,
	input  wire logic [RESULT_W-1:0] sample,
	// Result
	output logic                     bit_now,
	output logic [RESULT_W-1:0]      held
);
	logic [RESULT_W-1:0] acc_q;
	logic [RESULT_W-1:0] weight_q;
	logic [RESULT_W-1:0] trial;

	assign trial   = acc_q | weight_q;
	// Compare trial level against the held charge
	assign bit_now = (trial <= held);

	always_ff @(negedge sclk_int or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			held     <= CODE_ZERO;
			acc_q    <= CODE_ZERO;
			weight_q <= CODE_ZERO;
		end else if (load) begin
			held     <= sample;
			acc_q    <= CODE_ZERO;
			weight_q <= CODE_ONE << MSB_IDX;
		end else if (step) begin
			if (bit_now) begin
				acc_q <= trial;
			end
			weight_q <= weight_q >> 1;
		end
	end
endmodule // qsadc_sar

/* hdl/qsadc_ctrl.sv */
// Serial frame, track/hold sequencing and result shifting of the converter
//
// Contract
// R1: frame spans select low, 16-edge multiples
// R2: track for first three cycles
// R3: hold and convert cycles four to sixteen
// R4: result MSB first, from fifth cycle
// R5: data output driven only while selected
// R6: power down when deselected and between conversions
// R7: back-to-back conversions re-track and re-hold
// R8: gate clock off; select fall makes edge
// R9: clock idling high: first fall starts track
// R10: control word captured on first eight rises
// R11: address selects the following conversion
// R12: only control bits 5..3 carry address
// R13: low two address bits choose input
// R14: first conversion after power-up uses input a
// R15: no startup wait nor dummy conversion
// R16: straight-binary 12-bit unsigned result
// R17: host keeps select fall clear of clock fall
// R18: serial clock is the only timing source
// R19: power-down gap, continuous conversion while selected
// R20: host keeps clock at most 3.2 MHz; the bench host runs it with a 30 ns period
// R21: zeros before MSB, change on falling edge
`timescale 1ns/1ps
module qsadc_ctrl import qsadc_pkg::*; (
	// System clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	// Digitised front-end levels, on clk_sys
	input  wire logic [RESULT_W-1:0] analog_input_a,
	input  wire logic [RESULT_W-1:0] analog_input_b,
	input  wire logic [RESULT_W-1:0] analog_input_c,
	input  wire logic [RESULT_W-1:0] analog_input_d,
	// Serial link from the host
	input  wire logic                sclk,
	input  wire logic                cs_n,
	input  wire logic                sdi,
	output logic                     sdo,
	output logic                     sdo_oe,
	// Analog front-end control, link domain
	output logic [ADDR_W-1:0]        mux_sel,
	output logic                     track_en,
	output logic                     power_on,
	// Status on clk_sys
	output logic                     sys_conv_busy
);

	// ****************************************************************
	// Internal clock and frame reset
	// ****************************************************************
	logic sclk_int;
	logic frame_rst_n;

	// Frame state dies with the frame so a stopped clock cannot strand it
	assign frame_rst_n = rst_n & ~cs_n; // R1
	// Held high while deselected; a select fall with the clock low is
	// the first falling edge, with the clock high the next clock fall is.
	// Gated through the frame reset so that reset has lifted before the
	// edge it creates arrives; otherwise edge one could be swallowed
	assign sclk_int    = sclk | ~frame_rst_n; // R8 R9 R18

	// ****************************************************************
	// Sample bank crossing, clk_sys to link
	// ****************************************************************
	logic [RESULT_W-1:0] sys_in [CHAN_NUM];
	logic [RESULT_W-1:0] bank_q [CHAN_NUM];
	logic [RESULT_W-1:0] link_bank_q [CHAN_NUM];
	logic                req_q;
	logic                ack_q;
	logic                ack_sys;
	logic                req_link;
	logic                busy_link;

	assign sys_in[0] = analog_input_a;
	assign sys_in[1] = analog_input_b;
	assign sys_in[2] = analog_input_c;
	assign sys_in[3] = analog_input_d;

	qsadc_sync2 #(.W(1)) u_ack_sync (
		.clk   (clk_sys),
		.rst_n (rst_n),
		.d     (ack_q),
		.q     (ack_sys)
	);

	qsadc_sync2 #(.W(1)) u_req_sync (
		.clk   (sclk_int),
		.rst_n (rst_n),
		.d     (req_q),
		.q     (req_link)
	);

	qsadc_sync2 #(.W(1)) u_busy_sync (
		.clk   (clk_sys),
		.rst_n (rst_n),
		.d     (busy_link),
		.q     (sys_conv_busy)
	);

	// Bank only reloads once the link has taken the previous copy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= 1'b0;
		end else if (ack_sys == req_q) begin
			req_q <= ~req_q;
		end
	end

	generate
		for (genvar ch = 0; ch < CHAN_NUM; ch++) begin : g_bank
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					bank_q[ch] <= CODE_ZERO;
				end else if (ack_sys == req_q) begin
					bank_q[ch] <= sys_in[ch];
				end
			end

			// Bank is stable here: it changes only after ack returns
			always_ff @(posedge sclk_int or negedge rst_n) begin
				if (!rst_n) begin
					link_bank_q[ch] <= CODE_ZERO;
				end else if (req_link != ack_q) begin
					link_bank_q[ch] <= bank_q[ch];
				end
			end
		end
	endgenerate

	always_ff @(posedge sclk_int or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else if (req_link != ack_q) begin
			ack_q <= ~ack_q;
		end
	end

	// ****************************************************************
	// Falling-edge sequencer
	// ****************************************************************
	logic [PHASE_W-1:0] phase_q;
	qsadc_mode_e        mode_q;
	logic [ADDR_W-1:0]  chan_active_q;
	logic [ADDR_W-1:0]  chan_next_q;
	logic               sar_load;
	logic               sar_step;
	logic               sar_bit;
	logic [RESULT_W-1:0] sar_held;
	logic               sdo_q;
	logic               power_q;

	always_ff @(negedge sclk_int or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			phase_q <= PH_FRAME_START;
		end else begin
			// Wraps every 16 edges so conversions chain within a frame
			phase_q <= phase_q + PH_STEP; // R7 R19
		end
	end

	always_ff @(negedge sclk_int or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			mode_q <= QSADC_IDLE; // R6
		end else begin
			case (phase_q)
				PH_FRAME_START: mode_q <= QSADC_TRACK; // R2 R7
				PH_TRACK_LAST:  mode_q <= QSADC_HOLD;  // R3 R7
				PH_LAST:        mode_q <= QSADC_IDLE;  // R6 R19
				default:        mode_q <= mode_q;
			endcase
		end
	end

	// Own flop: a decode of the two-bit mode can glitch on TRACK to HOLD,
	// and this level is synchronised into clk_sys
	always_ff @(negedge sclk_int or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			power_q <= 1'b0; // R6
		end else begin
			case (phase_q)
				PH_FRAME_START: power_q <= 1'b1;    // R19
				PH_LAST:        power_q <= 1'b0;    // R6 R19
				default:        power_q <= power_q;
			endcase
		end
	end

	// Pipeline survives between frames, so only the power-up reset clears
	always_ff @(negedge sclk_int or negedge rst_n) begin
		if (!rst_n) begin
			chan_active_q <= CHAN_RESET; // R14 R15
		end else if (!cs_n && phase_q == PH_FRAME_START) begin
			chan_active_q <= chan_next_q; // R11
		end
	end

	assign sar_load = (phase_q == PH_TRACK_LAST);
	assign sar_step = (phase_q >= PH_HOLD);

	qsadc_sar u_sar (
		.sclk_int    (sclk_int),
		.frame_rst_n (frame_rst_n),
		.load        (sar_load),
		.step        (sar_step),
		.sample      (link_bank_q[chan_active_q]),
		.bit_now     (sar_bit),
		.held        (sar_held)
	);

	always_ff @(negedge sclk_int or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			sdo_q <= 1'b0;
		end else if (sar_step) begin
			sdo_q <= sar_bit; // R4 R16 R21
		end else begin
			sdo_q <= 1'b0; // R21
		end
	end

	// ****************************************************************
	// Rising-edge control word capture
	// ****************************************************************
	logic [PHASE_W-1:0]   rise_q;
	logic [CTRL_SH_W-1:0] ctrl_sh_q;

	always_ff @(posedge sclk_int or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rise_q    <= PH_FRAME_START;
			ctrl_sh_q <= '0;
		end else begin
			rise_q <= rise_q + PH_STEP;
			if (rise_q < RISE_CTRL_END) begin
				ctrl_sh_q <= {ctrl_sh_q[CTRL_SH_W-2:0], sdi}; // R10
			end
		end
	end

	// Upper address bit and the don't-care bits never reach the mux
	always_ff @(posedge sclk_int or negedge rst_n) begin
		if (!rst_n) begin
			chan_next_q <= CHAN_RESET; // R14
		end else if (!cs_n && rise_q == RISE_CTRL_LAST) begin
			chan_next_q <= ctrl_sh_q[ADDR_SH_HI:ADDR_SH_LO]; // R10 R12 R13
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign sdo       = sdo_q;
	assign sdo_oe    = ~cs_n; // R5
	assign mux_sel   = chan_active_q;
	assign track_en  = (mode_q == QSADC_TRACK);
	assign power_on  = power_q; // R6 R19
	assign busy_link = power_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_TRACK_SLOTS: assert property ( // R2
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q >= PH_STEP && phase_q <= PH_TRACK_LAST) |-> mode_q == QSADC_TRACK
	) else $error("not tracking in first three cycles");

	AST_HOLD_SLOTS: assert property ( // R3
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q >= PH_HOLD) |-> mode_q == QSADC_HOLD
	) else $error("not holding in cycles four to sixteen");

	AST_LEAD_ZERO: assert property ( // R21
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q >= PH_STEP && phase_q <= PH_HOLD) |-> !sdo
	) else $error("output not zero before first result bit");

	AST_MSB_SLOT: assert property ( // R4
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q == PH_MSB) |-> sdo == sar_held[MSB_IDX]
	) else $error("first result bit is not the held MSB");

	AST_LSB_SLOT: assert property ( // R16
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q == PH_LAST) ##1 (phase_q == PH_FRAME_START) |-> sdo == sar_held[0]
	) else $error("last result bit is not the held LSB");

	AST_POWER_GAP: assert property ( // R19
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q == PH_FRAME_START) |-> !power_on ##1 (power_on && track_en)
	) else $error("gap or re-track after sixteenth edge wrong");

	AST_CHAN_PIPE: assert property ( // R11
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q == PH_FRAME_START) |=> mux_sel == $past(chan_next_q)
	) else $error("mux did not take the previous address");

	AST_ADDR_CAPTURE: assert property ( // R10
		@(posedge sclk_int) disable iff (!frame_rst_n)
		(rise_q == RISE_CTRL_LAST) |=> chan_next_q == $past(ctrl_sh_q[ADDR_SH_HI:ADDR_SH_LO])
	) else $error("address not captured on eighth rising edge");

	AST_OUT_ENABLE: assert property ( // R5
		@(posedge clk_sys) disable iff (!rst_n)
		cs_n |-> !sdo_oe && !track_en
	) else $error("output driven or tracking while deselected");

	AST_POWER_MODE: assert property ( // R6
		@(negedge sclk_int) disable iff (!frame_rst_n)
		power_on == (mode_q != QSADC_IDLE)
	) else $error("power flag disagrees with converter mode");

	COV_BACK_TO_BACK: cover property (
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(phase_q == PH_LAST) ##1 (phase_q == PH_FRAME_START) ##1 track_en
	);

	COV_CHAN_D: cover property (
		@(negedge sclk_int) disable iff (!frame_rst_n)
		(mux_sel == 2'h3) && (phase_q == PH_MSB)
	);

	COV_SYS_BUSY: cover property (
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(sys_conv_busy)
	);

endmodule // qsadc_ctrl

/* dv/qsadc_host.sv */
// Host serial master model that frames conversions into the converter
`timescale 1ns/1ps
module qsadc_host (
	// Serial link to the converter
	output logic sclk,
	output logic cs_n,
	output logic sdi
);
	localparam time HALF = 15ns;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end

	// ****************************************************************
	// One frame of n conversions; hi parks the clock high between frames
	// ****************************************************************
	task automatic run(input int n, input bit hi, input logic [63:0] w);
		sclk = hi;
		#HALF;
		cs_n = 1'b0;
		if (hi) begin
			#10;
			sclk = 1'b0;
		end
		// Bits past the word are toggled so nothing leaks in by accident
		// Sixteen clocks per conversion; HALF is short only for bench speed
		for (int i = 0; i < 16 * n; i++) begin
			sdi = (i % 16 < 8) ? w[8 * (i / 16) + 7 - i % 16] : ~sdi;
			#HALF sclk = 1'b1;
			if (i != 16 * n - 1) #HALF sclk = 1'b0;
		end
		#10 cs_n = 1'b1;
		#5 sclk = hi;
		// Released line: never leave the last bit standing
		sdi = ~sdi;
	endtask
endmodule // qsadc_host

/* dv/tb_top.sv */
// Self-checking bench for the converter serial control block
`timescale 1ns/1ps
module tb_top;
	import qsadc_pkg::*;

	logic                clk_sys = 1'b0;
	logic                rst_n   = 1'b0;
	logic                sclk;
	logic                cs_n;
	logic                sdi;
	logic                sdo;
	logic                sdo_oe;
	logic                track_en;
	logic                power_on;
	logic                sys_conv_busy;
	logic [ADDR_W-1:0]   mux_sel;
	logic [RESULT_W-1:0] ain [CHAN_NUM];
	logic [ADDR_W-1:0]   cur_addr = CHAN_RESET;
	logic [17:0]         exp_q [$];
	logic [17:0]         e;
	logic [15:0]         rx;
	logic [15:0]         tv;
	logic [15:0]         pv;
	logic [3:0]          cnt;
	logic [63:0]         words;
	int                  n_mismatch = 0;
	int                  tests_run  = 0;
	int                  seed       = 32'h7058_e9d7;
	int                  conv       = 0;

	always #25 clk_sys = ~clk_sys;

	qsadc_ctrl qsadc_ctrl_i (
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.analog_input_a(ain[0]),
		.analog_input_b(ain[1]),
		.analog_input_c(ain[2]),
		.analog_input_d(ain[3]),
		.sclk          (sclk),
		.cs_n          (cs_n),
		.sdi           (sdi),
		.sdo           (sdo),
		.sdo_oe        (sdo_oe),
		.mux_sel       (mux_sel),
		.track_en      (track_en),
		.power_on      (power_on),
		.sys_conv_busy (sys_conv_busy)
	);

	qsadc_host qsadc_host_i (
		.sclk(sclk),
		.cs_n(cs_n),
		.sdi (sdi)
	);

	task automatic miss(input string m);
		n_mismatch++;
		$display("MISMATCH at %0t: %s", $time, m);
	endtask

	task automatic conclude();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// Monitor: host-side view of every rising edge inside a frame
	// ****************************************************************
	always @(negedge cs_n) cnt = 4'h0;

	always @(posedge sclk) if (cs_n === 1'b0) begin
		rx = {rx[14:0], sdo};
		tv = {tv[14:0], track_en};
		pv = {pv[14:0], power_on};
		cnt = cnt + 4'h1;
		tests_run += 1;
		if (sdo_oe !== 1'b1) miss("output not driven in frame");
		if (cnt == 4'ha) begin
			tests_run += 1;
			if (sys_conv_busy !== 1'b1) miss("busy low mid conversion");
		end
		if (cnt == 4'h0) begin
			tests_run += 3;
			if (exp_q.size() == 0) miss("unexpected conversion");
			else begin
				e = exp_q.pop_front();
				if ({mux_sel, rx} !== e) miss("result word or channel");
			end
			if (tv !== 16'he000) miss("track window");
			if (pv !== 16'hfffe) miss("power window");
		end
	end

	// ****************************************************************
	// Driver: notes what each conversion must return, then runs a frame
	// ****************************************************************
	task automatic frame(input int n, input bit hi);
		for (int c = 0; c < n; c++) begin
			words[8*c +: 8] = 8'($random(seed));
			words[8*c+3 +: 2] = 2'(conv);
			exp_q.push_back({cur_addr, 4'h0, ain[cur_addr]});
			cur_addr = words[8*c+3 +: 2];
			conv++;
		end
		@(negedge clk_sys);
		qsadc_host_i.run(n, hi, words);
		repeat (8) @(negedge clk_sys);
		tests_run += 3;
		if (sdo_oe !== 1'b0) miss("output driven while deselected");
		if (power_on !== 1'b0) miss("powered while deselected");
		if (sys_conv_busy !== 1'b0) miss("busy while deselected");
	endtask

	initial begin
		// Low bits carry the index so every input is told apart
		for (int i = 0; i < CHAN_NUM; i++) ain[i] = {10'($random(seed)), 2'(i)};
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (20) @(negedge clk_sys);
		// Frames of one to three conversions, clock parked low or high
		for (int f = 0; f < 8; f++) frame(1 + f % 3, 1'(f % 2));
		// Reset in mid-run drops the pending address back to the first input
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		cur_addr = CHAN_RESET;
		repeat (20) @(negedge clk_sys);
		for (int f = 0; f < 3; f++) frame(2, 1'(f % 2));
		for (int i = 0; i < 100 && exp_q.size() != 0; i++) @(negedge clk_sys);
		tests_run += 1;
		if (exp_q.size() != 0) miss("conversions missing");
		conclude();
	end
endmodule // tb_top
